// File: move_and_multiply_instr_exec.sv
// Execution unit for the copy, literal multiply and file multiply instructions.
`timescale 1ns/1ps
`default_nettype none

module move_and_multiply_instr_exec (
    // Clock and reset.
    input  wire logic                             clk_i,
    input  wire logic                             resetn_i,
    // Instruction issue.
    input  wire logic                             issue_i,
    input  wire logic [mulmove_pkg::WORD_W-1:0]   instr_i,
    output logic                                  ready_o,
    output logic                                  done_o,
    output logic                                  illegal_o,
    // Core context.
    input  wire logic [mulmove_pkg::DATA_W-1:0]   acc_i,
    input  wire logic [mulmove_pkg::BANK_W-1:0]   bank_select_reg_i,
    input  wire logic                             ext_en_i,
    input  wire logic [mulmove_pkg::ADDR_W-1:0]   index_base_i,
    // Data memory port.
    output logic      [mulmove_pkg::ADDR_W-1:0]   mem_addr_o,
    output logic                                  mem_rd_o,
    input  wire logic [mulmove_pkg::DATA_W-1:0]   mem_rdata_i,
    output logic                                  mem_wr_o,
    output logic      [mulmove_pkg::DATA_W-1:0]   mem_wdata_o,
    // Product register pair.
    output logic      [mulmove_pkg::DATA_W-1:0]   product_high_o,
    output logic      [mulmove_pkg::DATA_W-1:0]   product_low_o,
    // Phase indication.
    output logic      [1:0]                       phase_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release.

    logic [1:0] rst_sync;
    logic       rstn;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rstn = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        mulmove_pkg::phase_e             phase;
        logic                            busy;
        mulmove_pkg::op_e                op;
        logic [7:0]                      operand;
        logic                            acc_sel;
        logic [mulmove_pkg::DATA_W-1:0]  acc;
        logic [mulmove_pkg::DATA_W-1:0]  src;
        logic [mulmove_pkg::ADDR_W-1:0]  addr;
        logic [15:0]                     product;
        logic                            rd;
        logic                            wr;
        logic [mulmove_pkg::DATA_W-1:0]  wdata;
        logic                            done;
        logic                            illegal;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic [mulmove_pkg::ADDR_W-1:0] resolved_addr;
    mulmove_pkg::op_e               decoded_op;

    file_addr_resolve u_resolve (
        .file_i       (state_reg.operand),
        .acc_sel_i    (state_reg.acc_sel),
        .ext_en_i     (ext_en_i),
        .bank_i       (bank_select_reg_i),
        .index_base_i (index_base_i),
        .addr_o       (resolved_addr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the single program word.

    always_comb begin
        if (instr_i[15:9] == mulmove_pkg::OPC_COPY_HI) begin
            decoded_op = mulmove_pkg::OP_COPY;
        end else if (instr_i[15:9] == mulmove_pkg::OPC_MULF_HI) begin
            decoded_op = mulmove_pkg::OP_MULF;
        end else if (instr_i[15:8] == mulmove_pkg::OPC_MULL_HI) begin
            decoded_op = mulmove_pkg::OP_MULL;
        end else begin
            decoded_op = mulmove_pkg::OP_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Quarter phase sequence.

    always_comb begin
        state_next         = state_reg;
        state_next.rd      = 1'b0;
        state_next.wr      = 1'b0;
        state_next.done    = 1'b0;
        state_next.illegal = 1'b0;
        unique case (state_reg.phase)
            mulmove_pkg::PH_Q1: begin
                // Decode is taken only while idle, so one word is one instruction.
                if (issue_i) begin // see RULE_11
                    if (decoded_op == mulmove_pkg::OP_NONE) begin
                        state_next.illegal = 1'b1;
                    end else begin
                        state_next.busy    = 1'b1;
                        state_next.op      = decoded_op;
                        state_next.operand = instr_i[7:0]; // see RULE_10
                        state_next.acc_sel = instr_i[mulmove_pkg::ACC_SEL_BIT]; // see RULE_10
                        state_next.acc     = acc_i;
                        state_next.phase   = mulmove_pkg::PH_Q2;
                    end
                end
            end
            mulmove_pkg::PH_Q2: begin
                state_next.addr = resolved_addr; // see RULE_06
                if (state_reg.op == mulmove_pkg::OP_MULL) begin
                    state_next.src = state_reg.operand; // see RULE_09
                end else begin
                    // Read of the location is set up in this phase for both file forms and is on mem_rd_o in Q3.
                    state_next.rd = 1'b1; // see RULE_01
                end
                state_next.phase = mulmove_pkg::PH_Q3;
            end
            mulmove_pkg::PH_Q3: begin
                if (state_reg.op == mulmove_pkg::OP_MULF) begin
                    // Unsigned 8x8 fits 16 bits, so no overflow or carry exists.
                    state_next.product = state_reg.acc * mem_rdata_i; // see RULE_03
                end else if (state_reg.op == mulmove_pkg::OP_MULL) begin
                    state_next.product = state_reg.acc * state_reg.src; // see RULE_02
                end else begin
                    state_next.wdata = state_reg.acc; // see RULE_01
                end
                state_next.phase = mulmove_pkg::PH_Q4;
            end
            mulmove_pkg::PH_Q4: begin
                // The copy writes memory; multiplies never write memory.
                state_next.wr    = (state_reg.op == mulmove_pkg::OP_COPY); // see RULE_03
                state_next.done  = 1'b1; // see RULE_11
                state_next.busy  = 1'b0;
                state_next.phase = mulmove_pkg::PH_Q1;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            state_reg.phase   <= mulmove_pkg::PH_Q1;
            state_reg.busy    <= 1'b0;
            state_reg.op      <= mulmove_pkg::OP_NONE;
            state_reg.operand <= 8'h00;
            state_reg.acc_sel <= 1'b0;
            state_reg.acc     <= mulmove_pkg::ACC_RESET;
            state_reg.src     <= 8'h00;
            state_reg.addr    <= {mulmove_pkg::ADDR_W{1'b0}};
            state_reg.product <= mulmove_pkg::PROD_RESET;
            state_reg.rd      <= 1'b0;
            state_reg.wr      <= 1'b0;
            state_reg.wdata   <= 8'h00;
            state_reg.done    <= 1'b0;
            state_reg.illegal <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs. No status flag output exists, since none of these change flags.

    assign ready_o        = !state_reg.busy;
    assign done_o         = state_reg.done;
    assign illegal_o      = state_reg.illegal;
    assign mem_addr_o     = state_reg.addr;
    assign mem_rd_o       = state_reg.rd;
    assign mem_wr_o       = state_reg.wr;
    assign mem_wdata_o    = state_reg.wdata;
    assign product_high_o = state_reg.product[15:8]; // see RULE_04, RULE_05
    assign product_low_o  = state_reg.product[7:0]; // see RULE_04
    assign phase_o        = 2'(state_reg.phase);

endmodule

`default_nettype wire

// File: mulmove_pkg.sv
// Package with constants and types for the move and multiply execution block.
//
// Behaviour
// RULE_01: copy_acc_to_file decodes, reads, processes, then stores the working register, no flag.
// RULE_02: mul_literal puts working register times unsigned literal 0 to 255 in the product pair.
// RULE_03: mul_file puts working register times the location in the pair and keeps both sources.
// RULE_04: Both multiplies load the high byte into product_high, the low into product_low, no flag.
// RULE_05: Multiplication raises no overflow, carry or zero indication.
// RULE_06: With the access-select bit at 0 the file address resolves within the access bank.
// RULE_07: With access-select at 1, bank_select_reg gives the general_purpose_register bank.
// RULE_08: Extended set on and access-select 0: f up to 95 (5Fh) is indexed literal offset.
// RULE_09: mul_literal decodes, fetches the literal, computes, then writes the product pair.
// RULE_10: File-operand words carry an 8-bit file address 0 to 255 and one access-select bit.
// RULE_11: Each instruction is one program word done in one cycle of four quarter phases.
package mulmove_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int WORD_W = 16;

    // Opcode fields of the 16-bit program word.
    localparam logic [6:0] OPC_COPY_HI = 7'h37;
    localparam logic [6:0] OPC_MULF_HI = 7'h01;
    localparam logic [7:0] OPC_MULL_HI = 8'h0d;
    localparam int         ACC_SEL_BIT = 8;

    // Access bank split: 00h to 5Fh maps to bank 0, 60h to FFh to the last bank.
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEX_LIMIT  = 8'h5f;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    localparam logic [7:0]  ACC_RESET  = 8'h00;
    localparam logic [15:0] PROD_RESET = 16'h0000;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_COPY,
        OP_MULL,
        OP_MULF
    } op_e;

    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } phase_e;

endpackage

// File: file_addr_resolve.sv
// File address resolver for access bank, banked and indexed literal offset modes.
`timescale 1ns/1ps
`default_nettype none

module file_addr_resolve (
    // Operand.
    input  wire logic [7:0]                       file_i,
    input  wire logic                             acc_sel_i,
    // Context.
    input  wire logic                             ext_en_i,
    input  wire logic [mulmove_pkg::BANK_W-1:0]   bank_i,
    input  wire logic [mulmove_pkg::ADDR_W-1:0]   index_base_i,
    // Result.
    output logic      [mulmove_pkg::ADDR_W-1:0]   addr_o
);

    always_comb begin
        if (acc_sel_i) begin
            addr_o = {bank_i, file_i}; // see RULE_07
        end else if (ext_en_i && (file_i <= mulmove_pkg::INDEX_LIMIT)) begin
            // Offset wraps within the data space, as the core adder would.
            addr_o = index_base_i + {4'h0, file_i}; // see RULE_08
        end else if (file_i < mulmove_pkg::ACCESS_SPLIT) begin
            addr_o = {4'h0, file_i}; // see RULE_06
        end else begin
            addr_o = {mulmove_pkg::ACCESS_HIGH_BANK, file_i}; // see RULE_06
        end
    end

endmodule

`default_nettype wire

// File: mm_exec_monitor.sv
// Concurrent checks on the ports of the move and multiply execution block.
`timescale 1ns/1ps
`default_nettype none

module mm_exec_monitor (
    // Clock and reset.
    input wire logic        clk_i,
    input wire logic        resetn_i,
    // Issue and core context.
    input wire logic        issue_i,
    input wire logic [15:0] instr_i,
    input wire logic        ready_o,
    input wire logic        done_o,
    input wire logic [7:0]  acc_i,
    input wire logic [3:0]  bank_select_reg_i,
    input wire logic        ext_en_i,
    input wire logic [11:0] index_base_i,
    // Memory and products.
    input wire logic [11:0] mem_addr_o,
    input wire logic        mem_rd_o,
    input wire logic [7:0]  mem_rdata_i,
    input wire logic        mem_wr_o,
    input wire logic [7:0]  mem_wdata_o,
    input wire logic [7:0]  product_high_o,
    input wire logic [7:0]  product_low_o,
    input wire logic [1:0]  phase_o
);
    logic [15:0] w_q;
    logic [7:0]  a_q;
    logic [7:0]  k_q;
    wire         take  = issue_i && ready_o;
    wire         legal = instr_i[15:8] == 8'h0d || instr_i[15:9] == 7'h01
                         || instr_i[15:9] == 7'h37;
    wire         mul   = w_q[15:8] == 8'h0d || w_q[15:9] == 7'h01;
    wire [7:0]   f     = w_q[7:0];

    // The literal and the file operand share one register, as only one is used per word.
    always_ff @(posedge clk_i) begin
        if (take) begin
            w_q <= instr_i;
            a_q <= acc_i;
            k_q <= instr_i[7:0];
        end else if (mem_rd_o) begin
            k_q <= mem_rdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_done_bound: assert property (take && legal |-> ##[3:4] done_o)
        else $error("done missing after issue");
    a_done_single: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_read_single: assert property (mem_rd_o |=> !mem_rd_o)
        else $error("read strobe longer than one cycle");
    a_copy_data: assert property (mem_wr_o |-> !mul && mem_wdata_o == a_q)
        else $error("write data differs from working register");
    a_prod_value: assert property (
        done_o && mul |-> {product_high_o, product_low_o} == 16'(a_q) * 16'(k_q))
        else $error("product wrong");
    a_prod_hold: assert property ($changed({product_high_o, product_low_o}) |-> mul)
        else $error("product changed by copy");
    a_addr_bank: assert property (
        mem_rd_o && w_q[8] |-> mem_addr_o == {bank_select_reg_i, f})
        else $error("banked address wrong");
    a_addr_access: assert property (
        mem_rd_o && !w_q[8] && !(ext_en_i && f <= 8'h5f)
        |-> mem_addr_o == {(f < 8'h60) ? 4'h0 : 4'hf, f})
        else $error("access bank address wrong");
    a_addr_index: assert property (
        mem_rd_o && !w_q[8] && ext_en_i && f <= 8'h5f
        |-> mem_addr_o == index_base_i + {4'h0, f})
        else $error("indexed address wrong");
    a_phase_walk: assert property (
        take && legal |=> phase_o == 2'h1 ##1 phase_o == 2'h2 ##1 phase_o == 2'h3
        ##1 phase_o == 2'h0)
        else $error("phase sequence wrong");
    a_lit_no_read: assert property (mem_rd_o |-> w_q[15:8] != 8'h0d)
        else $error("literal multiply read memory");

    c_mul: cover property (take && legal && instr_i[15:8] == 8'h0d);
    c_write: cover property (mem_wr_o);
    c_index: cover property (mem_rd_o && ext_en_i && !w_q[8]);
endmodule

`default_nettype wire

// File: move_and_multiply_instr_exec_tb_top.sv
// Testbench for the move and multiply execution block.
`timescale 1ns/1ps
`default_nettype none

module move_and_multiply_instr_exec_tb_top;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        issue_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic [7:0]  acc_i = 8'h00;
    logic [3:0]  bank_select_reg_i = 4'h0;
    logic        ext_en_i = 1'b0;
    logic [11:0] index_base_i = 12'h000;
    logic [7:0]  mem_rdata_i = 8'h00;
    logic        ready_o, done_o, illegal_o, mem_rd_o, mem_wr_o, seen_wr, seen_ill;
    logic [11:0] mem_addr_o, got_addr;
    logic [7:0]  mem_wdata_o, product_high_o, product_low_o, got_wdata;
    logic [1:0]  phase_o;
    logic [15:0] prod_seen;
    int          error_cnt = 0;
    int          check_count = 0;

    always #2.5 clk_i = ~clk_i;

    assign prod_seen = {product_high_o, product_low_o};

    move_and_multiply_instr_exec uut (.clk_i(clk_i), .resetn_i(resetn_i), .issue_i(issue_i),
        .instr_i(instr_i), .ready_o(ready_o), .done_o(done_o), .illegal_o(illegal_o),
        .acc_i(acc_i), .bank_select_reg_i(bank_select_reg_i), .ext_en_i(ext_en_i),
        .index_base_i(index_base_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
        .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
        .product_high_o(product_high_o), .product_low_o(product_low_o), .phase_o(phase_o));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Issues one word and records the memory strobes until done or refusal.
    task automatic exec(input logic [15:0] w, input logic [7:0] a);
        int n;
        n = 0;
        @(negedge clk_i);
        while (ready_o !== 1'b1) @(negedge clk_i);
        instr_i = w;
        acc_i = a;
        issue_i = 1'b1;
        seen_wr = 1'b0;
        seen_ill = 1'b0;
        @(negedge clk_i);
        issue_i = 1'b0;
        repeat (8) begin
            if (mem_rd_o === 1'b1) got_addr = mem_addr_o;
            if (mem_wr_o === 1'b1) got_wdata = mem_wdata_o;
            seen_wr |= mem_wr_o;
            seen_ill |= illegal_o;
            if (done_o === 1'b1 || illegal_o === 1'b1) break;
            @(negedge clk_i);
            n++;
        end
        check("cycles", 16'h1, 16'(n <= 4));
    endtask

    task automatic t_copy();
        bank_select_reg_i = 4'h3;
        exec({7'h37, 1'b1, 8'h20}, 8'h4f);
        check("copy strobe", 16'h1, 16'(seen_wr));
        check("copy data", 16'h4f, 16'(got_wdata));
        check("copy addr", 16'h0320, 16'(got_addr));
        // Runs after the literal multiplies, so the last product must still stand.
        check("copy product", 16'hfe01, prod_seen);
    endtask

    task automatic t_mull();
        logic [31:0] tv [3] = '{32'he2c4ad08, 32'h01000000, 32'hfffffe01};
        foreach (tv[i]) begin
            exec({8'h0d, tv[i][23:16]}, tv[i][31:24]);
            check("mull product", tv[i][15:0], prod_seen);
            check("mull write", 16'h0, 16'(seen_wr));
        end
    endtask

    task automatic t_mulf();
        mem_rdata_i = 8'hb5;
        exec({7'h01, 1'b1, 8'h85}, 8'hc4);
        check("mulf product", 16'h8a94, {product_high_o, product_low_o});
        check("mulf write", 16'h0, 16'(seen_wr));
    endtask

    // The whole address table runs through file multiplies so no memory word is disturbed.
    task automatic t_addr();
        logic [31:0] tv [8] = '{32'h00100010, 32'h00800f80, 32'h01800580, 32'h01ff05ff,
                                32'h105f015f, 32'h10000100, 32'h10600f60, 32'h11100510};
        logic [11:0] ea;
        bank_select_reg_i = 4'h5;
        index_base_i = 12'h100;
        foreach (tv[i]) begin
            ext_en_i = tv[i][28];
            exec({7'h01, tv[i][24], tv[i][23:16]}, 8'h02);
            ea = tv[i][11:0];
            check("file addr", 16'(ea), 16'(got_addr));
        end
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        check("ready", 16'h1, 16'(ready_o));
        check("reset product", 16'h0, {product_high_o, product_low_o});
        t_mull();
        t_copy();
        t_mulf();
        t_addr();
        exec(16'hffff, 8'h11);
        check("refused word", 16'h1, 16'(seen_ill & ~seen_wr));
        complete_run();
    end

    // Fourteen words at a few cycles each finish far inside this span.
    initial begin
        #20000;
        error_cnt++;
        complete_run();
    end
endmodule

bind move_and_multiply_instr_exec mm_exec_monitor u_mon (.clk_i(clk_i), .resetn_i(resetn_i),
    .issue_i(issue_i), .instr_i(instr_i), .ready_o(ready_o), .done_o(done_o), .acc_i(acc_i),
    .bank_select_reg_i(bank_select_reg_i), .ext_en_i(ext_en_i), .index_base_i(index_base_i),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .product_high_o(product_high_o),
    .product_low_o(product_low_o), .phase_o(phase_o));

`default_nettype wire
